// ===== src/pcsm_monitor.sv
// Press contact sequence monitor: checks cam switch order, drives the
// enable, top-zone and upstroke indications and latches faults.
// Assumes cam and restart switches are asynchronous pins, while
// drive_command and enable_in come from logic on core_clk.
// How it works
// - Restart counts only for a high pulse between the minimum and thirty seconds.
// - With restart enabled, a valid restart pulse clears every latched fault.
// - With restart disabled, only a reset clears a latched fault.
// - Fault summary is high during any fault when the summary is enabled.
// - One top switch pulse per press cycle; extra or missing pulses fault.
// - Bottom already high at start keeps upstroke low the first cycle.
// - In dual mode a second bottom rise never reasserts upstroke.
// - In dual mode a cycle without bottom pulse leaves upstroke low, no fault.
// - After a start with bottom high, bottom rises wait for top-zone to fall.
// - Drive command must rise after top-zone rise or be high at overtravel fall.
// - Failing that, enable drops and overtravel fault and reset pending rise.
// - Enable input low without fault holds enable low and suspends checks.
// - Enable input falling clears enable, top-zone and upstroke, keeps faults.
// - Enable input rising enters the state fitting the present contacts.
// - Contacts in an invalid order raise the sequence fault.
// - Upstroke rises on bottom rise, falls on top rise or bottom fall.
// - Top-zone is high while the top switch is low, low on fault.
// - A sequence fault drops enable, raises its fault and reset pending.
// - Reset pending clears only by valid restart or reset; enable never high meanwhile.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module pcsm_monitor #(
   parameter logic [31:0] MIN_SHORT_CYC = pcsm_pkg::MIN_SHORT_CYC,
   parameter logic [31:0] MIN_LONG_CYC = pcsm_pkg::MIN_LONG_CYC,
   parameter logic [31:0] MAX_HIGH_CYC = pcsm_pkg::MAX_HIGH_CYC
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic top_position_switch,
   input wire logic bottom_position_switch,
   input wire logic overtravel_switch,
   input wire logic restart_switch,
   input wire logic drive_command,
   input wire logic enable_in,
   output logic enable_out,
   output logic top_zone,
   output logic upstroke,
   output logic seq_fault,
   output logic ot_fault,
   output logic reset_pending,
   output logic fault_summary
);
   localparam int PN = pcsm_pkg::PIN_COUNT;

   pcsm_pkg::pcsm_ctrl_type ctrl, next_ctrl;
   logic [31:0] next_rdata;
   logic [PN-1:0] raw, s1, s2, s3, filt, prev, next_filt;
   logic drive_prev;
   logic [31:0] rcnt, next_rcnt;
   logic restart_ok;
   pcsm_pkg::pcsm_state_type state, next_state;
   pcsm_pkg::pcsm_out_type outs, next_outs;
   logic partial, next_partial, bblk, next_bblk;
   logic cmd_seen, next_cmd_seen, ot_armed, next_ot_armed;
   logic ot_seen, next_ot_seen, next_up;
   logic [1:0] bcnt, next_bcnt;
   logic seq_err, ot_err;
   logic t_rise, t_fall, b_rise, b_fall, o_fall, r_fall, d_rise;

   // Register port: writes and read data both register at the edge that samples the strobe
   always_comb begin
      next_ctrl = ctrl;
      next_rdata = 32'h0;
      if (reg_wr && reg_addr == pcsm_pkg::CTRL_ADDR) begin
         next_ctrl = pcsm_pkg::pcsm_ctrl_type'(reg_wdata[pcsm_pkg::CTRL_WIDTH-1:0]);
      end
      if (reg_rd) begin
         case (reg_addr)
            pcsm_pkg::CTRL_ADDR: begin
               next_rdata = {27'h0, ctrl};
            end
            pcsm_pkg::STATUS_ADDR: begin
               next_rdata = {21'h0, bcnt, state, outs};
            end
            default: begin
               next_rdata = 32'h0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= pcsm_pkg::pcsm_ctrl_type'(pcsm_pkg::CTRL_RESET);
         reg_rdata <= 32'h0;
      end else begin
         ctrl <= next_ctrl;
         reg_rdata <= next_rdata;
      end
   end

   // Pin filter: a change counts once stages two and three agree
   assign raw = {restart_switch, overtravel_switch, bottom_position_switch,
                 top_position_switch};
   genvar gi;
   generate
      for (gi = 0; gi < PN; gi++) begin : g_filt
         assign next_filt[gi] = (s2[gi] == s3[gi]) ? s3[gi] : filt[gi];
      end
   endgenerate

   // Sampled every cycle; prev holds last cycle's value for edges
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         filt <= '0;
         prev <= '0;
         drive_prev <= 1'b1; // No false rise if the drive already runs at release
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         prev <= filt;
         drive_prev <= drive_command;
      end
   end

   // Edge strobes from filtered samples; the drive edge comes from drive_command unfiltered
   assign t_rise = filt[pcsm_pkg::PIN_TOP] & ~prev[pcsm_pkg::PIN_TOP];
   assign t_fall = ~filt[pcsm_pkg::PIN_TOP] & prev[pcsm_pkg::PIN_TOP];
   assign b_rise = filt[pcsm_pkg::PIN_BOTTOM] & ~prev[pcsm_pkg::PIN_BOTTOM];
   assign b_fall = ~filt[pcsm_pkg::PIN_BOTTOM] & prev[pcsm_pkg::PIN_BOTTOM];
   assign o_fall = ~filt[pcsm_pkg::PIN_OVER] & prev[pcsm_pkg::PIN_OVER];
   assign r_fall = ~filt[pcsm_pkg::PIN_RESTART] & prev[pcsm_pkg::PIN_RESTART];
   assign d_rise = drive_command & ~drive_prev;

   // Restart timer saturates one past the maximum so a held button never wraps
   always_comb begin
      next_rcnt = 32'h0;
      if (filt[pcsm_pkg::PIN_RESTART]) begin
         next_rcnt = (rcnt > MAX_HIGH_CYC) ? rcnt : rcnt + 32'h1;
      end
   end
   assign restart_ok = r_fall && rcnt <= MAX_HIGH_CYC &&
      rcnt >= (ctrl.long_min ? MIN_LONG_CYC : MIN_SHORT_CYC);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rcnt <= 32'h0;
      end else begin
         rcnt <= next_rcnt;
      end
   end

   // Sequence checker and state machine
   always_comb begin
      next_state = state;
      next_partial = partial;
      next_bblk = bblk;
      next_cmd_seen = cmd_seen;
      next_ot_armed = ot_armed;
      next_ot_seen = ot_seen;
      next_bcnt = bcnt;
      next_up = outs.upstroke;
      seq_err = 1'b0;
      ot_err = 1'b0;
      case (state)
         pcsm_pkg::ST_HOLD: begin
            next_up = 1'b0;
            if (enable_in && s1 == s2 && s2 == s3 && filt == s3) begin
               // Settled filter first, so a pin held since reset is no false edge
               next_state = pcsm_pkg::ST_RUN;
               next_partial = 1'b1; // Mid-cycle start skips counts until a top rise
               next_bblk = filt[pcsm_pkg::PIN_BOTTOM];
               next_bcnt = pcsm_pkg::BCNT_NONE;
               next_cmd_seen = 1'b0;
               next_ot_armed = 1'b0;
               next_ot_seen = 1'b0;
            end
         end
         pcsm_pkg::ST_RUN: begin
            if (!enable_in) begin
               next_state = pcsm_pkg::ST_HOLD;
               next_up = 1'b0;
            end else begin
               if (d_rise) begin
                  next_cmd_seen = 1'b1;
               end
               if (b_rise && !bblk) begin
                  if (!filt[pcsm_pkg::PIN_TOP]) begin
                     seq_err = 1'b1;
                  end else if (bcnt == pcsm_pkg::BCNT_NONE) begin
                     next_up = 1'b1;
                     next_bcnt = pcsm_pkg::BCNT_ONE;
                  end else if (!ctrl.dual_bottom || bcnt == pcsm_pkg::BCNT_TWO) begin
                     seq_err = 1'b1;
                  end else begin
                     next_bcnt = pcsm_pkg::BCNT_TWO;
                  end
               end
               if (b_fall) begin
                  next_up = 1'b0;
               end
               if (t_rise) begin
                  // Bottom must already be clear; one top pulse per overtravel pulse
                  if (filt[pcsm_pkg::PIN_BOTTOM] && !bblk) begin
                     seq_err = 1'b1;
                  end
                  if (ctrl.ot_en && !ot_seen && !partial) begin
                     seq_err = 1'b1;
                  end
                  next_up = 1'b0;
                  next_partial = 1'b0;
                  next_bblk = 1'b0;
                  next_ot_seen = 1'b0;
                  next_bcnt = pcsm_pkg::BCNT_NONE;
               end
               if (t_fall) begin
                  // A silent cycle is legal only in dual mode
                  if (!partial && !ctrl.dual_bottom && bcnt == pcsm_pkg::BCNT_NONE) begin
                     seq_err = 1'b1;
                  end
                  next_up = 1'b0;
                  next_cmd_seen = d_rise;
                  next_ot_armed = 1'b1;
               end
               if (ctrl.ot_en && !partial && !filt[pcsm_pkg::PIN_TOP] &&
                   !filt[pcsm_pkg::PIN_OVER]) begin
                  seq_err = 1'b1;
               end
               if (o_fall) begin
                  next_ot_seen = 1'b1;
                  next_ot_armed = 1'b0;
                  if (ctrl.ot_en && ot_armed && !cmd_seen && !d_rise && !drive_command) begin
                     ot_err = 1'b1;
                  end
               end
               if (seq_err || ot_err) begin
                  next_state = pcsm_pkg::ST_FAULT;
                  next_up = 1'b0;
               end
            end
         end
         pcsm_pkg::ST_FAULT: begin
            next_up = 1'b0;
            if (ctrl.restart_en && restart_ok) begin
               next_state = pcsm_pkg::ST_HOLD;
            end
         end
         default: begin
            next_state = pcsm_pkg::ST_HOLD;
            next_up = 1'b0;
         end
      endcase
   end

   // Outputs follow the next state so they change with it
   always_comb begin
      next_outs.enable_out = next_state == pcsm_pkg::ST_RUN;
      next_outs.top_zone = next_state == pcsm_pkg::ST_RUN &&
         !filt[pcsm_pkg::PIN_TOP];
      next_outs.upstroke = next_state == pcsm_pkg::ST_RUN && next_up && !next_bblk;
      next_outs.seq_fault = outs.seq_fault | seq_err;
      next_outs.ot_fault = outs.ot_fault | ot_err;
      next_outs.reset_pending = next_state == pcsm_pkg::ST_FAULT;
      if (state == pcsm_pkg::ST_FAULT && next_state != pcsm_pkg::ST_FAULT) begin
         next_outs.seq_fault = 1'b0;
         next_outs.ot_fault = 1'b0;
      end
      next_outs.fault_summary = ctrl.summary_en &&
         (next_outs.seq_fault || next_outs.ot_fault);
   end

   // Only reset clears faults when restart is disabled
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= pcsm_pkg::ST_HOLD;
         outs <= '0;
         partial <= 1'b1;
         bblk <= 1'b0;
         cmd_seen <= 1'b0;
         ot_armed <= 1'b0;
         ot_seen <= 1'b0;
         bcnt <= pcsm_pkg::BCNT_NONE;
      end else begin
         state <= next_state;
         outs <= next_outs;
         partial <= next_partial;
         bblk <= next_bblk;
         cmd_seen <= next_cmd_seen;
         ot_armed <= next_ot_armed;
         ot_seen <= next_ot_seen;
         bcnt <= next_bcnt;
      end
   end

   assign enable_out = outs.enable_out;
   assign top_zone = outs.top_zone;
   assign upstroke = outs.upstroke;
   assign seq_fault = outs.seq_fault;
   assign ot_fault = outs.ot_fault;
   assign reset_pending = outs.reset_pending;
   assign fault_summary = outs.fault_summary;

   // Checks on the monitor's own outputs
   pend_blocks_en_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      reset_pending |-> !enable_out) else $error("enable high with reset pending");
   short_restart_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state == pcsm_pkg::ST_FAULT && r_fall && !restart_ok) |=> reset_pending)
      else $error("bad restart pulse cleared a fault");
   restart_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state == pcsm_pkg::ST_FAULT && restart_ok && ctrl.restart_en)
      |=> !reset_pending && !seq_fault && !ot_fault) else $error("restart failed");
   no_restart_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (reset_pending && !ctrl.restart_en) |=> reset_pending)
      else $error("fault cleared without restart input");
   summary_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ctrl.summary_en && $past(ctrl.summary_en) && (seq_fault || ot_fault))
      |-> fault_summary) else $error("fault summary low during fault");
   first_cycle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      bblk |-> !upstroke) else $error("upstroke during blocked first cycle");
   second_bottom_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (state == pcsm_pkg::ST_RUN && b_rise && bcnt != pcsm_pkg::BCNT_NONE)
      |=> !$rose(upstroke)) else $error("second bottom rise restarted upstroke");
   overtravel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ot_err |=> ot_fault && reset_pending && !enable_out ##1 !enable_out)
      else $error("overtravel not latched");
   en_fall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      $fell(enable_in) |=> !enable_out && !top_zone && !upstroke &&
      $stable(seq_fault) && $stable(ot_fault)) else $error("enable fall outputs wrong");
   hold_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!enable_in && !reset_pending)[*2] |-> !enable_out && $stable(seq_fault))
      else $error("checking while enable input low");
   seq_fault_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      seq_err |=> seq_fault && reset_pending && !enable_out && !top_zone)
      else $error("sequence fault not latched");
endmodule

// ===== src/pcsm_pkg.sv
// Constants and types shared by the press contact sequence monitor.
// Assumes a 125 MHz core clock and a 32-bit register port.
package pcsm_pkg;
   // Core clock rate and the restart pulse limits in their own units
   localparam longint unsigned CLK_HZ = 64'h7735940;
   localparam longint unsigned MIN_SHORT_MS = 64'h64;
   localparam longint unsigned MIN_LONG_MS = 64'h15e;
   localparam longint unsigned MAX_HIGH_MS = 64'h7530;
   // Least times round up, the longest time rounds down
   localparam logic [31:0] MIN_SHORT_CYC = 32'((MIN_SHORT_MS * CLK_HZ + 64'h3e7) / 64'h3e8);
   localparam logic [31:0] MIN_LONG_CYC = 32'((MIN_LONG_MS * CLK_HZ + 64'h3e7) / 64'h3e8);
   localparam logic [31:0] MAX_HIGH_CYC = 32'((MAX_HIGH_MS * CLK_HZ) / 64'h3e8);

   // Register byte addresses
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;

   // Control field positions and reset value
   localparam int CTRL_RESTART_EN = 0;
   localparam int CTRL_DUAL_BOTTOM = 1;
   localparam int CTRL_LONG_MIN = 2;
   localparam int CTRL_SUMMARY_EN = 3;
   localparam int CTRL_OT_EN = 4;
   localparam int CTRL_WIDTH = 5;
   localparam logic [4:0] CTRL_RESET = 5'h11;

   // Bit positions of the synchronised pin vector
   localparam int PIN_TOP = 0;
   localparam int PIN_BOTTOM = 1;
   localparam int PIN_OVER = 2;
   localparam int PIN_RESTART = 3;
   localparam int PIN_COUNT = 4;

   // Bottom edge counts within one press cycle
   localparam logic [1:0] BCNT_NONE = 2'h0;
   localparam logic [1:0] BCNT_ONE = 2'h1;
   localparam logic [1:0] BCNT_TWO = 2'h2;

   // Monitor states, Gray coded along hold, run, fault
   typedef enum logic [1:0] {
      ST_HOLD = 2'h0,
      ST_RUN = 2'h1,
      ST_FAULT = 2'h3
   } pcsm_state_type;

   typedef struct packed {
      logic ot_en;
      logic summary_en;
      logic long_min;
      logic dual_bottom;
      logic restart_en;
   } pcsm_ctrl_type;

   typedef struct packed {
      logic fault_summary;
      logic reset_pending;
      logic ot_fault;
      logic seq_fault;
      logic upstroke;
      logic top_zone;
      logic enable_out;
   } pcsm_out_type;
endpackage

// ===== tb/pcsm_press_model.sv
// Behavioural press seen from the monitor: cam contacts and the drive command flag.
// Assumes the bench calls move to step the press, changing one or more contacts per step.
`timescale 1ns/1ns
module pcsm_press_model (
   input wire logic core_clk,
   output logic top_position_switch,
   output logic bottom_position_switch,
   output logic overtravel_switch,
   output logic drive_command
);
   // Start condition of a press cycle: top and bottom released, overtravel made
   initial begin
      top_position_switch = 1'b0;
      bottom_position_switch = 1'b0;
      overtravel_switch = 1'b1;
      drive_command = 1'b1;
   end

   // One contact step; the wait covers the three-flop pin filter plus the output register
   task automatic move(input logic t, input logic b, input logic o, input logic d);
      @(posedge core_clk);
      top_position_switch <= t;
      bottom_position_switch <= b;
      overtravel_switch <= o;
      drive_command <= d;
      repeat (7) @(posedge core_clk);
   endtask
endmodule

// ===== tb/press_contact_sequence_monitor_test.sv
// Self-checking bench for the press contact sequence monitor.
// Assumes pcsm_pkg and pcsm_monitor are compiled first; restart limits are shrunk.
`timescale 1ns/1ns
module press_contact_sequence_monitor_test;
   logic core_clk, sys_rst, reg_wr, reg_rd, restart_switch, enable_in;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rdv;
   logic top_position_switch, bottom_position_switch, overtravel_switch, drive_command;
   logic enable_out, top_zone, upstroke, seq_fault, ot_fault, reset_pending, fault_summary;
   logic [6:0] out_vec;
   int n_errors = 0;
   int n_tests = 0;

   assign out_vec = {fault_summary, reset_pending, ot_fault, seq_fault, upstroke, top_zone,
      enable_out};

   // Small limits keep restart pulses short: minimum 10 or 20, maximum 100 cycles
   pcsm_monitor #(.MIN_SHORT_CYC(32'h0000000a), .MIN_LONG_CYC(32'h00000014),
      .MAX_HIGH_CYC(32'h00000064)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .top_position_switch(top_position_switch), .bottom_position_switch(bottom_position_switch),
      .overtravel_switch(overtravel_switch), .restart_switch(restart_switch),
      .drive_command(drive_command), .enable_in(enable_in), .enable_out(enable_out),
      .top_zone(top_zone), .upstroke(upstroke), .seq_fault(seq_fault), .ot_fault(ot_fault),
      .reset_pending(reset_pending), .fault_summary(fault_summary));

   pcsm_press_model u_press (
      .core_clk(core_clk), .top_position_switch(top_position_switch),
      .bottom_position_switch(bottom_position_switch), .overtravel_switch(overtravel_switch),
      .drive_command(drive_command));

   // 125 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Output order: summary, pending, overtravel, sequence, upstroke, top zone, enable
   task automatic see(input logic [6:0] exp);
      #1;
      chk("outputs", {25'h0, out_vec}, {25'h0, exp});
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Reset with the press at its start condition, then set the configuration
   task automatic start(input logic [31:0] ctrl);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      wr(pcsm_pkg::CTRL_ADDR, ctrl);
      repeat (8) @(posedge core_clk);
   endtask

   task automatic pulse(input int n);
      @(posedge core_clk);
      restart_switch <= 1'b1;
      repeat (n) @(posedge core_clk);
      restart_switch <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask

   // Bottom rise while top is released is an out-of-order contact
   task automatic bump();
      u_press.move(1'b0, 1'b1, 1'b1, 1'b1);
      u_press.move(1'b0, 1'b0, 1'b1, 1'b1);
   endtask

   // One press stroke with nb bottom pulses; d low means the drive stayed off
   task automatic cyc(input int nb, input logic d);
      u_press.move(1'b1, 1'b0, 1'b1, d);
      see(7'h01);
      u_press.move(1'b1, 1'b0, 1'b0, d);
      if (!d) begin
         see(7'h30);
         return;
      end
      see(7'h01);
      for (int k = 0; k < nb; k++) begin
         u_press.move(1'b1, 1'b1, 1'b0, d);
         see(k == 0 ? 7'h05 : 7'h01);
         u_press.move(1'b1, 1'b0, 1'b0, d);
         see(7'h01);
      end
      u_press.move(1'b1, 1'b0, 1'b1, d);
      u_press.move(1'b0, 1'b0, 1'b1, d);
      see(7'h03);
   endtask

   task automatic t_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      see(7'h00);
      start(32'h00000011);
      rd(pcsm_pkg::CTRL_ADDR, rdv);
      chk("ctrl reset", rdv, 32'h00000011);
      rd(4'hc, rdv);
      chk("unmapped read", rdv, 32'h00000000);
      rd(pcsm_pkg::STATUS_ADDR, rdv);
      chk("status", rdv, 32'h00000083);
      see(7'h03);
      $display("done reset");
   endtask

   task automatic t_strokes();
      cyc(1, 1'b1);
      cyc(1, 1'b1);
      start(32'h00000013);
      cyc(1, 1'b1);
      cyc(0, 1'b1);
      cyc(2, 1'b1);
      $display("done strokes");
   endtask

   task automatic t_restart();
      start(32'h00000019);
      cyc(1, 1'b1);
      bump();
      see(7'h68);
      pulse(9);
      see(7'h68);
      pulse(101);
      see(7'h68);
      pulse(10);
      see(7'h03);
      start(32'h00000015);
      bump();
      pulse(19);
      see(7'h28);
      pulse(20);
      see(7'h03);
      start(32'h00000010);
      bump();
      pulse(10);
      see(7'h28);
      start(32'h00000010);
      see(7'h03);
      $display("done restart");
   endtask

   task automatic t_over();
      start(32'h00000011);
      cyc(1, 1'b1);
      cyc(1, 1'b0);
      $display("done overtravel");
   endtask

   task automatic t_enable();
      start(32'h00000011);
      u_press.move(1'b1, 1'b0, 1'b1, 1'b1);
      u_press.move(1'b1, 1'b0, 1'b0, 1'b1);
      u_press.move(1'b1, 1'b1, 1'b0, 1'b1);
      see(7'h05);
      @(posedge core_clk);
      enable_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      see(7'h00);
      u_press.move(1'b0, 1'b0, 1'b0, 1'b1);
      u_press.move(1'b0, 1'b1, 1'b1, 1'b1);
      see(7'h00);
      u_press.move(1'b0, 1'b0, 1'b1, 1'b1);
      enable_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      see(7'h03);
      bump();
      enable_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      see(7'h28);
      @(posedge core_clk);
      enable_in <= 1'b1;
      $display("done enable");
   endtask

   task automatic t_bottom_high();
      start(32'h00000011);
      enable_in <= 1'b0;
      u_press.move(1'b1, 1'b1, 1'b1, 1'b1);
      enable_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      see(7'h01);
      u_press.move(1'b1, 1'b0, 1'b1, 1'b1);
      u_press.move(1'b1, 1'b1, 1'b1, 1'b1);
      see(7'h01);
      u_press.move(1'b1, 1'b0, 1'b1, 1'b1);
      u_press.move(1'b0, 1'b0, 1'b1, 1'b1);
      see(7'h03);
      cyc(1, 1'b1);
      $display("done bottom high at start");
   endtask

   task automatic summarize();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Watchdog well beyond the fewer than a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      restart_switch = 1'b0;
      enable_in = 1'b1;
      t_reset();
      t_strokes();
      t_restart();
      t_over();
      t_enable();
      t_bottom_high();
      summarize();
   end
endmodule
